// [crwo_pkg.sv]
// How it works
// [RULE1] Byte clear writes zero to the target and sets only the zero flag.
// [RULE2] Opcode 0110101, bank bit, file address; bit 0 picks access bank.
// [RULE3] Bank bit 1 joins the bank select register with the file address.
// [RULE4] Extended set, bank bit 0, address to 5Fh: indexed literal offset.
// [RULE5] Watchdog clear opcode 0004h zeroes counter and postscaler.
// [RULE6] Watchdog clear sets timeout and powerdown flags; others unchanged.
// [RULE7] Both instructions take one word and finish in one cycle.
package crwo_pkg;

  // Data memory addressing
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int FILE_W = 8;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [7:0] BYTE_CLEAR = 8'h00;

  // Opcodes
  localparam logic [6:0] CLEAR_BYTE_PATTERN = 7'h35;
  localparam int CLEAR_BYTE_PAT_LSB = 9;
  localparam int CLEAR_BYTE_BANK_BIT = 8;
  localparam logic [15:0] CLEAR_DOG_OPCODE = 16'h0004;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BANK = 8'h04;
  localparam logic [7:0] OFS_INDEX = 8'h08;
  localparam logic [7:0] OFS_INSTR = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DOG = 8'h14;
  localparam logic [7:0] OFS_MADDR = 8'h18;
  localparam logic [7:0] OFS_MDATA = 8'h1c;
  localparam logic [7:0] OFS_TARGET = 8'h20;
  localparam int OFS_W = 8;

  // Field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int ST_Z_BIT = 2;
  localparam int ST_ALU_W = 5;
  localparam int ST_TIMEOUT_BIT = 8;
  localparam int ST_PWRDN_BIT = 9;
  localparam int DOG_POST_LSB = 16;
  localparam int TGT_IDX_BIT = 16;

  // Reset values
  localparam logic [4:0] ST_ALU_RST = 5'h00;
  localparam logic ST_TIMEOUT_RST = 1'b1;
  localparam logic ST_PWRDN_RST = 1'b1;
  localparam logic [15:0] DOG_POST_RST = 16'h0000;

  // Watchdog defaults
  localparam int DOG_W = 8;
  localparam int POST_W = 16;
  localparam int DOG_PRESCALE = 128;
  localparam int DOG_POSTSCALE = 4;

  // AHB-Lite
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [3:0] {
    CRWO_R_CTRL,
    CRWO_R_BANK,
    CRWO_R_INDEX,
    CRWO_R_INSTR,
    CRWO_R_STATUS,
    CRWO_R_DOG,
    CRWO_R_MADDR,
    CRWO_R_MDATA,
    CRWO_R_TARGET,
    CRWO_R_NONE
  } crwo_reg_t;

endpackage

// [crwo_decode.sv]
module crwo_decode (
  // Instruction word
  input wire logic [15:0] opcode,
  // Decoded fields
  output logic clear_file_byte_op,
  output logic clear_watchdog_op,
  output logic bank_bit,
  output logic [7:0] file_addr
);

  always_comb begin
    clear_file_byte_op = opcode[15:crwo_pkg::CLEAR_BYTE_PAT_LSB]
                         == crwo_pkg::CLEAR_BYTE_PATTERN; // [RULE2]
    clear_watchdog_op = opcode == crwo_pkg::CLEAR_DOG_OPCODE; // [RULE5]
    bank_bit = opcode[crwo_pkg::CLEAR_BYTE_BANK_BIT];
    file_addr = opcode[crwo_pkg::FILE_W-1:0];
  end

endmodule

// [crwo_addr.sv]
module crwo_addr #(
  parameter int AW = crwo_pkg::ADDR_W
) (
  // Address sources
  input wire logic [crwo_pkg::BANK_W-1:0] bank_select_register,
  input wire logic [AW-1:0] index_base,
  input wire logic ext_enable,
  input wire logic bank_bit,
  input wire logic [7:0] file_addr,
  // Resolved target
  output logic [AW-1:0] target,
  output logic indexed
);

  logic low_half;

  always_comb begin
    low_half = file_addr <= crwo_pkg::ACCESS_LIMIT;
    indexed = ext_enable && !bank_bit && low_half; // [RULE4]
    if (bank_bit) begin
      target = AW'({bank_select_register, file_addr}); // [RULE3]
    end else if (indexed) begin
      target = AW'(index_base + AW'(file_addr)); // [RULE4]
    end else if (low_half) begin
      target = AW'({crwo_pkg::ACCESS_LO_BANK, file_addr}); // [RULE2]
    end else begin
      target = AW'({crwo_pkg::ACCESS_HI_BANK, file_addr}); // [RULE2]
    end
  end

endmodule

// [crwo_top.sv]
module crwo_top #(
  parameter int AW = crwo_pkg::ADDR_W,
  parameter int PRESCALE = crwo_pkg::DOG_PRESCALE,
  parameter int POSTSCALE = crwo_pkg::DOG_POSTSCALE
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Status
  output logic ZERO_FLAG,
  output logic TIMEOUT_FLAG,
  output logic POWERDOWN_FLAG
);

  localparam int DEPTH = 1 << AW;

  logic rst_meta_q;
  logic rst_n;
  logic [crwo_pkg::OFS_W-1:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic acc;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic ext_enable_q;
  logic [crwo_pkg::BANK_W-1:0] bank_select_register;
  logic [AW-1:0] index_base_q;
  logic [15:0] instr_q;
  logic [crwo_pkg::ST_ALU_W-1:0] alu_flags_q;
  logic timeout_flag;
  logic powerdown_flag;
  logic [crwo_pkg::DOG_W-1:0] watchdog_counter;
  logic [crwo_pkg::POST_W-1:0] post_q;
  logic [crwo_pkg::POST_W-1:0] pre_q;
  logic pre_tick;
  logic dog_wrap;
  logic [AW-1:0] maddr_q;
  logic [AW-1:0] target_q;
  logic indexed_q;
  logic [7:0] mem [DEPTH];
  crwo_pkg::crwo_reg_t wsel;
  logic wr_now;
  logic exec;
  logic clear_file_byte_op;
  logic clear_watchdog_op;
  logic bank_bit;
  logic [7:0] file_addr;
  logic [AW-1:0] target;
  logic indexed;
  logic byte_clr_go;
  logic dog_go;

  function automatic crwo_pkg::crwo_reg_t reg_of(
    input logic [crwo_pkg::OFS_W-1:0] ofs
  );
    case (ofs)
      crwo_pkg::OFS_CTRL: reg_of = crwo_pkg::CRWO_R_CTRL;
      crwo_pkg::OFS_BANK: reg_of = crwo_pkg::CRWO_R_BANK;
      crwo_pkg::OFS_INDEX: reg_of = crwo_pkg::CRWO_R_INDEX;
      crwo_pkg::OFS_INSTR: reg_of = crwo_pkg::CRWO_R_INSTR;
      crwo_pkg::OFS_STATUS: reg_of = crwo_pkg::CRWO_R_STATUS;
      crwo_pkg::OFS_DOG: reg_of = crwo_pkg::CRWO_R_DOG;
      crwo_pkg::OFS_MADDR: reg_of = crwo_pkg::CRWO_R_MADDR;
      crwo_pkg::OFS_MDATA: reg_of = crwo_pkg::CRWO_R_MDATA;
      crwo_pkg::OFS_TARGET: reg_of = crwo_pkg::CRWO_R_TARGET;
      default: reg_of = crwo_pkg::CRWO_R_NONE;
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Address phase capture; upper address bits outside the window alias
  assign acc = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (HREADY) begin
      wr_q <= acc && HWRITE;
      rd_q <= acc && !HWRITE;
      if (acc) begin
        addr_q <= {HADDR[crwo_pkg::OFS_W-1:2], 2'b00};
      end
    end
  end

  // Reads take one wait state so a preceding write is always visible
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= !(acc && !HWRITE);
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= '0;
    end else if (rd_q && !HREADY) begin
      hrdata_q <= '0;
      unique case (reg_of(addr_q))
        crwo_pkg::CRWO_R_CTRL:
          hrdata_q[crwo_pkg::CTRL_EXT_BIT] <= ext_enable_q;
        crwo_pkg::CRWO_R_BANK:
          hrdata_q[crwo_pkg::BANK_W-1:0] <= bank_select_register;
        crwo_pkg::CRWO_R_INDEX: hrdata_q[AW-1:0] <= index_base_q;
        crwo_pkg::CRWO_R_INSTR: hrdata_q[15:0] <= instr_q;
        crwo_pkg::CRWO_R_STATUS: begin
          hrdata_q[crwo_pkg::ST_ALU_W-1:0] <= alu_flags_q;
          hrdata_q[crwo_pkg::ST_TIMEOUT_BIT] <= timeout_flag;
          hrdata_q[crwo_pkg::ST_PWRDN_BIT] <= powerdown_flag;
        end
        crwo_pkg::CRWO_R_DOG: begin
          hrdata_q[crwo_pkg::DOG_W-1:0] <= watchdog_counter;
          hrdata_q[crwo_pkg::DOG_POST_LSB +: crwo_pkg::POST_W] <= post_q;
        end
        crwo_pkg::CRWO_R_MADDR: hrdata_q[AW-1:0] <= maddr_q;
        crwo_pkg::CRWO_R_MDATA: hrdata_q[7:0] <= mem[maddr_q];
        crwo_pkg::CRWO_R_TARGET: begin
          hrdata_q[AW-1:0] <= target_q;
          hrdata_q[crwo_pkg::TGT_IDX_BIT] <= indexed_q;
        end
        crwo_pkg::CRWO_R_NONE: hrdata_q <= '0;
      endcase
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = hreadyout_q;
  assign HRESP = crwo_pkg::HRESP_OKAY;

  // Write data phase
  assign wr_now = wr_q && HREADY;
  assign wsel = reg_of(addr_q);
  assign exec = wr_now && (wsel == crwo_pkg::CRWO_R_INSTR);

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ext_enable_q <= 1'b0;
      bank_select_register <= '0;
      index_base_q <= '0;
      maddr_q <= '0;
    end else if (wr_now) begin
      if (wsel == crwo_pkg::CRWO_R_CTRL) begin
        ext_enable_q <= HWDATA[crwo_pkg::CTRL_EXT_BIT];
      end
      if (wsel == crwo_pkg::CRWO_R_BANK) begin
        bank_select_register <= HWDATA[crwo_pkg::BANK_W-1:0];
      end
      if (wsel == crwo_pkg::CRWO_R_INDEX) begin
        index_base_q <= HWDATA[AW-1:0];
      end
      if (wsel == crwo_pkg::CRWO_R_MADDR) begin
        maddr_q <= HWDATA[AW-1:0];
      end
    end
  end

  // Instruction decode and target resolution
  crwo_decode u_decode (
    .opcode(HWDATA[15:0]),
    .clear_file_byte_op(clear_file_byte_op),
    .clear_watchdog_op(clear_watchdog_op),
    .bank_bit(bank_bit),
    .file_addr(file_addr)
  );

  crwo_addr #(
    .AW(AW)
  ) u_addr (
    .bank_select_register(bank_select_register),
    .index_base(index_base_q),
    .ext_enable(ext_enable_q),
    .bank_bit(bank_bit),
    .file_addr(file_addr),
    .target(target),
    .indexed(indexed)
  );

  assign byte_clr_go = exec && clear_file_byte_op; // [RULE7]
  assign dog_go = exec && clear_watchdog_op; // [RULE7]

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      instr_q <= '0;
      target_q <= '0;
      indexed_q <= 1'b0;
    end else if (exec) begin
      instr_q <= HWDATA[15:0];
      if (clear_file_byte_op) begin
        target_q <= target;
        indexed_q <= indexed;
      end
    end
  end

  // Data memory: instruction clear takes the port over a software write
  always_ff @(posedge CLK_SYS) begin
    if (byte_clr_go) begin
      mem[target] <= crwo_pkg::BYTE_CLEAR; // [RULE1]
    end else if (wr_now && wsel == crwo_pkg::CRWO_R_MDATA) begin
      mem[maddr_q] <= HWDATA[7:0];
    end
  end

  // Arithmetic flags: only zero is touched by a clear
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      alu_flags_q <= crwo_pkg::ST_ALU_RST;
    end else if (byte_clr_go) begin
      alu_flags_q[crwo_pkg::ST_Z_BIT] <= 1'b1; // [RULE1]
    end else if (wr_now && wsel == crwo_pkg::CRWO_R_STATUS) begin
      alu_flags_q <= HWDATA[crwo_pkg::ST_ALU_W-1:0];
    end
  end

  // Timeout and powerdown flags; instruction set wins over any clear
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag <= crwo_pkg::ST_TIMEOUT_RST;
      powerdown_flag <= crwo_pkg::ST_PWRDN_RST;
    end else if (dog_go) begin
      timeout_flag <= 1'b1; // [RULE6]
      powerdown_flag <= 1'b1; // [RULE6]
    end else begin
      if (wr_now && wsel == crwo_pkg::CRWO_R_STATUS) begin
        timeout_flag <= HWDATA[crwo_pkg::ST_TIMEOUT_BIT];
        powerdown_flag <= HWDATA[crwo_pkg::ST_PWRDN_BIT];
      end
      if (dog_wrap) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // Free-running prescaler gives the watchdog tick enable
  assign pre_tick = pre_q == crwo_pkg::POST_W'(PRESCALE - 1);

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (pre_tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Postscaler and counter; wrap marks a watchdog timeout
  assign dog_wrap = pre_tick && post_q == crwo_pkg::POST_W'(POSTSCALE - 1)
                    && (&watchdog_counter) && !dog_go;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      post_q <= crwo_pkg::DOG_POST_RST;
      watchdog_counter <= '0;
    end else if (dog_go) begin
      post_q <= crwo_pkg::DOG_POST_RST; // [RULE5]
      watchdog_counter <= '0; // [RULE5]
    end else if (pre_tick) begin
      if (post_q == crwo_pkg::POST_W'(POSTSCALE - 1)) begin
        post_q <= crwo_pkg::DOG_POST_RST;
        watchdog_counter <= watchdog_counter + 1'b1;
      end else begin
        post_q <= post_q + 1'b1;
      end
    end
  end

  // Status pins
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ZERO_FLAG <= 1'b0;
      TIMEOUT_FLAG <= crwo_pkg::ST_TIMEOUT_RST;
      POWERDOWN_FLAG <= crwo_pkg::ST_PWRDN_RST;
    end else begin
      ZERO_FLAG <= alu_flags_q[crwo_pkg::ST_Z_BIT];
      TIMEOUT_FLAG <= timeout_flag;
      POWERDOWN_FLAG <= powerdown_flag;
    end
  end

endmodule

// [crwo_asserts.sv]
module crwo_asserts #(
  parameter int AW = crwo_pkg::ADDR_W,
  parameter int PRESCALE = crwo_pkg::DOG_PRESCALE,
  parameter int POSTSCALE = crwo_pkg::DOG_POSTSCALE
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Status
  input wire logic ZERO_FLAG,
  input wire logic TIMEOUT_FLAG,
  input wire logic POWERDOWN_FLAG
);
  logic instr_q;
  logic take;
  logic dp;
  logic byte_clr;
  logic dog_clr;
  assign take = HSEL && HTRANS[1] && HREADY;
  assign dp = instr_q && HREADY;
  assign byte_clr = dp && HWDATA[15:9] == crwo_pkg::CLEAR_BYTE_PATTERN;
  assign dog_clr = dp && HWDATA[15:0] == crwo_pkg::CLEAR_DOG_OPCODE;
  // Marks the data phase of a write to the instruction register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      instr_q <= 1'b0;
    end else if (HREADY) begin
      instr_q <= take && HWRITE
                 && {HADDR[7:2], 2'b00} == crwo_pkg::OFS_INSTR;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_clear_zero_set: assert property (byte_clr |-> ##2 ZERO_FLAG)
    else $error("zero flag not set by clear byte");
  a_clear_pwrdn_kept: assert property (
    byte_clr |-> ##2 POWERDOWN_FLAG == $past(POWERDOWN_FLAG, 2))
    else $error("powerdown flag moved on clear byte");
  a_dog_flags_set: assert property (
    dog_clr |-> ##2 TIMEOUT_FLAG && POWERDOWN_FLAG)
    else $error("timeout or powerdown not set");
  a_dog_zero_kept: assert property (
    dog_clr |-> ##2 ZERO_FLAG == $past(ZERO_FLAG, 2))
    else $error("zero flag moved on watchdog clear");
  a_other_op_inert: assert property (
    dp && !byte_clr && !dog_clr |-> ##2 ZERO_FLAG == $past(ZERO_FLAG, 2)
      && POWERDOWN_FLAG == $past(POWERDOWN_FLAG, 2))
    else $error("unknown opcode changed flags");
  a_write_one_cycle: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write not finished in one cycle");
  a_read_one_wait: assert property (
    take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_resp_okay: assert property (HRESP == crwo_pkg::HRESP_OKAY)
    else $error("response not okay");
  cover property (byte_clr);
  cover property (dog_clr);
  cover property (take && !HWRITE);
  cover property (dp && !byte_clr && !dog_clr);
endmodule

bind crwo_top crwo_asserts #(.AW(AW), .PRESCALE(PRESCALE),
  .POSTSCALE(POSTSCALE)) u_crwo_asserts (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .ZERO_FLAG(ZERO_FLAG), .TIMEOUT_FLAG(TIMEOUT_FLAG),
  .POWERDOWN_FLAG(POWERDOWN_FLAG));

// [crwo_top_tb_top.sv]
module crwo_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] op;
    logic [3:0] bank;
    logic ext;
    logic [11:0] idx;
    logic [31:0] st;
    logic [31:0] tgt;
  } crwo_row_t;
  logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, zf, tf, pf;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [15:0] bad_ops [4];
  int fails, tests_run;
  crwo_row_t rows [7];

  crwo_top #(.PRESCALE(4), .POSTSCALE(8)) u_crwo_top (.CLK_SYS(clk_sys),
    .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .ZERO_FLAG(zf), .TIMEOUT_FLAG(tf), .POWERDOWN_FLAG(pf));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Wait for the slave to be ready at a rising edge; the 100000 ns timeout ends a hang
  task automatic rdy();
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  initial begin
    #100000;
    fails++;
    stop_test();
  end

  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, rst_n} = '0;
    fails = 0;
    tests_run = 0;
    bad_ops = '{16'h0003, 16'h0005, 16'h6c00, 16'h6800};
    rows[0] = '{16'h6b10, 4'h2, 1'b0, 12'h000, 32'h21b, 32'h00000210};
    rows[1] = '{16'h6bff, 4'hf, 1'b0, 12'h000, 32'h000, 32'h00000fff};
    rows[2] = '{16'h6a5f, 4'h3, 1'b0, 12'h000, 32'h213, 32'h0000005f};
    rows[3] = '{16'h6a60, 4'h3, 1'b0, 12'h000, 32'h00a, 32'h00000f60};
    rows[4] = '{16'h6a5f, 4'h3, 1'b1, 12'hffa, 32'h211, 32'h00010059};
    rows[5] = '{16'h6a60, 4'h3, 1'b1, 12'hffa, 32'h203, 32'h00000f60};
    rows[6] = '{16'h6b00, 4'h5, 1'b1, 12'hffa, 32'h000, 32'h00000500};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_pin(zf, 1'b0);
    chk_pin(hresp, 1'b0);
    chk_pin(tf, 1'b1);
    rdc(crwo_pkg::OFS_STATUS, 32'h300);
    rdc(crwo_pkg::OFS_CTRL, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(crwo_pkg::OFS_CTRL, {31'h0, rows[i].ext});
      wr(crwo_pkg::OFS_BANK, {28'h0, rows[i].bank});
      wr(crwo_pkg::OFS_INDEX, {20'h0, rows[i].idx});
      wr(crwo_pkg::OFS_MADDR, {20'h0, rows[i].tgt[11:0]});
      wr(crwo_pkg::OFS_MDATA, 32'h5a);
      wr(crwo_pkg::OFS_STATUS, rows[i].st);
      wr(crwo_pkg::OFS_INSTR, {16'h0, rows[i].op});
      rdc(crwo_pkg::OFS_MDATA, 32'h0);
      rdc(crwo_pkg::OFS_TARGET, rows[i].tgt);
      rdc(crwo_pkg::OFS_STATUS, rows[i].st | 32'h4);
      chk_pin(zf, 1'b1);
      $display("row %0d done", i);
    end
    wr(crwo_pkg::OFS_STATUS, 32'h01b);
    repeat (40) @(posedge clk_sys);
    bus(1'b0, crwo_pkg::OFS_DOG, 32'h0);
    chk({31'h0, rd[7:0] != 8'h00}, 32'h1);
    wr(crwo_pkg::OFS_INSTR, 32'h0004);
    bus(1'b0, crwo_pkg::OFS_DOG, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h0);
    chk({31'h0, rd[31:16] < 16'h2}, 32'h1);
    rdc(crwo_pkg::OFS_STATUS, 32'h31b);
    chk_pin(pf, 1'b1);
    chk_pin(tf, 1'b1);
    chk_pin(zf, 1'b0);
    $display("watchdog clear test done");
    foreach (bad_ops[i]) begin
      wr(crwo_pkg::OFS_STATUS, 32'h0);
      wr(crwo_pkg::OFS_INSTR, {16'h0, bad_ops[i]});
      rdc(crwo_pkg::OFS_STATUS, 32'h0);
      rdc(crwo_pkg::OFS_INSTR, {16'h0, bad_ops[i]});
    end
    wr(crwo_pkg::OFS_TARGET, 32'h0);
    rdc(crwo_pkg::OFS_TARGET, 32'h500);
    rdc(8'h40, 32'h0);
    $display("unknown opcode test done");
    stop_test();
  end
endmodule
